// ==== core/alu_pkg.sv ====
// package: constants, opcodes and carriers for the add and status datapath
package alu_pkg;
    // ==========================================
    // widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam logic [6:0] RPAGE_LAST = 7'h1f;
    // ==========================================
    // flag positions in the status vector
    localparam int FLAG_C_POS = 0;
    localparam int FLAG_HC_POS = 1;
    localparam int FLAG_Z_POS = 2;
    localparam int HALF_POS = 4;
    // ==========================================
    // reset values and destination select codes
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic PWRDN_RST = 1'b1;
    localparam logic TO_RST = 1'b1;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // ==========================================
    // decoded operation
    typedef enum logic [7:0] {
        OP_NONE = 8'h01,
        OP_ADD_REG_CARRY = 8'h02,
        OP_ADD_REG = 8'h04,
        OP_ADD_IMM_CARRY = 8'h08,
        OP_ADD_IMM = 8'h10,
        OP_AND_REG = 8'h20,
        OP_BIT_CLEAR = 8'h40,
        OP_SPECIAL = 8'h80
    } op_t;

    // ==========================================
    // one decoded instruction from the sequencer
    typedef struct packed {
        logic valid;
        op_t op;
        logic [6:0] reg_addr;
        logic dest_sel;
        logic [2:0] bit_sel;
        logic [7:0] imm;
        logic watchdog_clear_instr;
        logic sleep_instr;
    } instr_t;

    // register file write request
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    // arithmetic flags
    typedef struct packed {
        logic zero;
        logic half_carry;
        logic carry;
    } flags_t;
endpackage

// ==== core/adder8.sv ====
// leaf: 8-bit adder with carry-in, half-carry and carry out
`timescale 1ns/1ps
module adder8
    import alu_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic cin,
    output logic [WIDTH-1:0] sum,
    output logic half_carry,
    output logic carry
);
    logic [WIDTH:0] full;
    logic [HALF_POS:0] low;

    // =====================================
    // sums
    // the low nibble sum gives the carry out of bit 3
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
        low = {1'b0, a[HALF_POS-1:0]} + {1'b0, b[HALF_POS-1:0]}
            + {{HALF_POS{1'b0}}, cin};
        sum = full[WIDTH-1:0];
        carry = full[WIDTH];
        half_carry = low[HALF_POS];
    end
endmodule

// ==== core/add_status_datapath.sv ====
// main: add, and, bit clear datapath with arithmetic and power flags
`timescale 1ns/1ps
// Function
// - power-down flag: one at reset/clear, zero sleep
// - timeout flag set by reset, clear, sleep
// - timeout flag cleared on watchdog expiry
// - register page addresses run zero to 1f
// - destination bit zero accumulator, one register
// - register add with carry, flags, one cycle
// - register add without carry, flags, one cycle
// - immediate add with carry into accumulator
// - immediate add without carry into accumulator
// - register and, zero flag only
// - bit clear, flags untouched
// - carry flag is carry out of msb
module add_status_datapath
    import alu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire instr_t instr,
    input wire logic [7:0] reg_rd_data,
    input wire logic watchdog_expired,
    output logic [6:0] reg_rd_addr,
    output reg_wr_t reg_wr,
    output logic [7:0] accumulator,
    output flags_t flags,
    output logic power_down_flag,
    output logic timeout_flag,
    output logic rpage_hit
);
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    flags_t flags_reg;
    flags_t flags_next;
    logic pd_reg;
    logic pd_next;
    logic to_reg;
    logic to_next;
    reg_wr_t wr_reg;
    reg_wr_t wr_next;
    logic [7:0] add_b;
    logic add_cin;
    logic [7:0] add_sum;
    logic add_hc;
    logic add_c;
    logic [7:0] result;
    logic is_add;
    logic to_acc;

    // =====================================
    // register read port
    // read address passes straight to the file so the operand is ready
    assign reg_rd_addr = instr.reg_addr;
    // operands in the low page are special function registers
    assign rpage_hit = (instr.reg_addr <= RPAGE_LAST);

    // =====================================
    // adder operand selection
    always_comb begin
        add_b = reg_rd_data;
        add_cin = 1'b0;
        is_add = 1'b0;
        case (instr.op)
            OP_ADD_REG_CARRY: begin
                add_cin = flags_reg.carry;
                is_add = 1'b1;
            end
            OP_ADD_REG: begin
                is_add = 1'b1;
            end
            OP_ADD_IMM_CARRY: begin
                add_b = instr.imm;
                add_cin = flags_reg.carry;
                is_add = 1'b1;
            end
            OP_ADD_IMM: begin
                add_b = instr.imm;
                is_add = 1'b1;
            end
            default: begin
                is_add = 1'b0;
            end
        endcase
    end

    adder8 #(
        .WIDTH(DATA_W)
    ) u_adder (
        .a(acc_reg),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .half_carry(add_hc),
        .carry(add_c)
    );

    // =====================================
    // result, destination and flag next values
    always_comb begin
        acc_next = acc_reg;
        flags_next = flags_reg;
        wr_next = '0;
        wr_next.addr = instr.reg_addr;
        result = add_sum;
        to_acc = 1'b1;
        if (instr.valid) begin
            case (instr.op)
                OP_ADD_REG_CARRY, OP_ADD_REG: begin
                    result = add_sum;
                    to_acc = (instr.dest_sel == DEST_ACC);
                end
                OP_ADD_IMM_CARRY, OP_ADD_IMM: begin
                    result = add_sum;
                    to_acc = 1'b1;
                end
                OP_AND_REG: begin
                    result = acc_reg & reg_rd_data;
                    to_acc = (instr.dest_sel == DEST_ACC);
                end
                OP_BIT_CLEAR: begin
                    result = reg_rd_data;
                    result[instr.bit_sel] = 1'b0;
                    to_acc = 1'b0;
                end
                default: begin
                    result = acc_reg;
                    to_acc = 1'b1;
                end
            endcase
            if (instr.op != OP_NONE && instr.op != OP_SPECIAL) begin
                if (to_acc) begin
                    acc_next = result;
                end else begin
                    wr_next.we = 1'b1;
                    wr_next.data = result;
                end
            end
            // and touches zero only; bit clear touches nothing
            if (is_add) begin
                flags_next.zero = (result == 8'h00);
                flags_next.half_carry = add_hc;
                flags_next.carry = add_c;
            end else if (instr.op == OP_AND_REG) begin
                flags_next.zero = (result == 8'h00);
            end
        end
    end

    // =====================================
    // power and timeout status next values
    // expiry wins over a clear or sleep in the same cycle for the
    // timeout flag (power-down still follows the instruction) so a
    // watchdog restart is never hidden
    always_comb begin
        pd_next = pd_reg;
        to_next = to_reg;
        if (instr.valid && instr.op == OP_SPECIAL) begin
            if (instr.watchdog_clear_instr) begin
                pd_next = 1'b1;
                to_next = 1'b1;
            end else if (instr.sleep_instr) begin
                pd_next = 1'b0;
                to_next = 1'b1;
            end
        end
        if (watchdog_expired) begin
            to_next = 1'b0;
        end
    end

    // =====================================
    // state registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_reg <= ACC_RST;
            flags_reg <= '{FLAG_RST, FLAG_RST, FLAG_RST};
            pd_reg <= PWRDN_RST;
            to_reg <= TO_RST;
            wr_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            flags_reg <= flags_next;
            pd_reg <= pd_next;
            to_reg <= to_next;
            wr_reg <= wr_next;
        end
    end

    // =====================================
    // outputs from flip-flops
    assign accumulator = acc_reg;
    assign flags = flags_reg;
    assign power_down_flag = pd_reg;
    assign timeout_flag = to_reg;
    assign reg_wr = wr_reg;
endmodule

// ==== tb/reg_file_model.sv ====
// partner: 128-byte register file facing the datapath
`timescale 1ns/1ps
module reg_file_model
    import alu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [6:0] reg_rd_addr,
    input wire reg_wr_t reg_wr,
    output logic [7:0] reg_rd_data
);
    // ==========================================
    // storage
    logic [7:0] mem [128];
    // reads are same-cycle, as the datapath expects
    assign reg_rd_data = mem[reg_rd_addr];
    // reset loads a known pattern so the bench can predict operands
    always @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < 128; i++) begin
                mem[i] <= 8'h30 + 8'(i);
            end
        end else if (reg_wr.we) begin
            mem[reg_wr.addr] <= reg_wr.data;
        end
    end
endmodule

// ==== tb/add_status_datapath_properties.sv ====
// checker: port timing of the add and status datapath
`timescale 1ns/1ps
module add_status_properties
    import alu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire instr_t instr,
    input wire logic [7:0] reg_rd_data,
    input wire logic watchdog_expired,
    input wire logic [6:0] reg_rd_addr,
    input wire reg_wr_t reg_wr,
    input wire logic [7:0] accumulator,
    input wire flags_t flags,
    input wire logic power_down_flag,
    input wire logic timeout_flag,
    input wire logic rpage_hit
);
    // ==========================================
    // assertions on the core clock
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire go = instr.valid;
    // sleep and clear are only meaningful on the special opcode
    wire spc = go && (instr.op == OP_SPECIAL);
    wire sl = spc && instr.sleep_instr;
    wire cl = spc && instr.watchdog_clear_instr;
    rd_addr_a: assert property (reg_rd_addr == instr.reg_addr)
        else $error("read address off");
    rpage_a: assert property (rpage_hit == (instr.reg_addr <= 7'h1f))
        else $error("page hit off");
    sleep_pd_a: assert property (sl && !cl |=> !power_down_flag)
        else $error("sleep kept power down flag");
    clear_pd_a: assert property (cl |=> power_down_flag)
        else $error("clear left power down flag low");
    to_set_a: assert property (
        (cl || sl) && !watchdog_expired |=> timeout_flag)
        else $error("timeout flag not set");
    expiry_to_a: assert property (watchdog_expired |=> !timeout_flag)
        else $error("expiry kept timeout flag");
    reg_dest_a: assert property (
        go && instr.op == OP_ADD_REG && instr.dest_sel |=> reg_wr.we
        && reg_wr.addr == $past(instr.reg_addr)
        && flags.zero == (reg_wr.data == 8'h00))
        else $error("register add write wrong");
    imm_acc_a: assert property (
        go && instr.op == OP_ADD_IMM |=> !reg_wr.we
        && flags.zero == (accumulator == 8'h00))
        else $error("immediate add wrong");
    and_keep_a: assert property (
        go && instr.op == OP_AND_REG
        |=> $stable(flags.carry) && $stable(flags.half_carry))
        else $error("and touched carries");
    bclr_a: assert property (
        go && instr.op == OP_BIT_CLEAR |=> $stable(flags) && reg_wr.we
        && !reg_wr.data[$past(instr.bit_sel)])
        else $error("bit clear wrong");
endmodule

bind add_status_datapath add_status_properties props (.clk_sys(clk_sys),
    .rst(rst), .instr(instr), .reg_rd_data(reg_rd_data),
    .watchdog_expired(watchdog_expired), .reg_rd_addr(reg_rd_addr),
    .reg_wr(reg_wr), .accumulator(accumulator), .flags(flags),
    .power_down_flag(power_down_flag), .timeout_flag(timeout_flag),
    .rpage_hit(rpage_hit));

// ==== tb/add_status_datapath_bench.sv ====
// bench: instruction sequences against predicted state
`timescale 1ns/1ps
module add_status_datapath_bench;
    import alu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    instr_t instr = '0;
    logic watchdog_expired = 1'b0;
    logic [7:0] reg_rd_data;
    logic [6:0] reg_rd_addr;
    reg_wr_t reg_wr;
    logic [7:0] accumulator;
    flags_t flags;
    logic power_down_flag;
    logic timeout_flag;
    logic rpage_hit;
    int err_total = 0;
    int checked = 0;
    // ==========================================
    // clock, design and register file
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    add_status_datapath DUT (.clk_sys(clk_sys), .rst(rst), .instr(instr),
        .reg_rd_data(reg_rd_data), .watchdog_expired(watchdog_expired),
        .reg_rd_addr(reg_rd_addr), .reg_wr(reg_wr),
        .accumulator(accumulator), .flags(flags),
        .power_down_flag(power_down_flag), .timeout_flag(timeout_flag),
        .rpage_hit(rpage_hit));
    reg_file_model far_end (.clk_sys(clk_sys), .rst(rst),
        .reg_rd_addr(reg_rd_addr), .reg_wr(reg_wr),
        .reg_rd_data(reg_rd_data));
    // ==========================================
    // helpers
    task automatic end_of_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // state: acc, flags, pd, to, write (masked when no write)
    function automatic logic [28:0] st();
        return {accumulator, flags, power_down_flag, timeout_flag,
            reg_wr.we ? reg_wr : 16'h0000};
    endfunction
    // ctl is {clear, sleep, expiry}; dbit is {dest, bit}
    task automatic run(input op_t op, input logic [6:0] a,
        input logic [3:0] dbit, input logic [7:0] imm,
        input logic [2:0] ctl, input logic [28:0] exp);
        instr = {1'b1, op, a, dbit, imm, ctl[2:1]};
        watchdog_expired = ctl[0];
        @(posedge clk_sys);
        #1;
        chk({3'b0, st()}, {3'b0, exp});
        // instr still holds this call's address until the next call
        chk({25'h0, reg_rd_addr}, {25'h0, a});
        chk({31'h0, rpage_hit}, {31'h0, (a <= 7'h1f)});
    endtask
    // hang guard: the sequence needs well under 100 cycles
    initial begin
        #20000;
        err_total++;
        end_of_test();
    end
    // ==========================================
    // back-to-back instruction sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        chk({3'b0, st()}, {11'h000, 2'b11, 16'h0});
        rst = 1'b0;
        run(OP_ADD_IMM, 7'h00, 4'h0, 8'h12, 3'b000, {8'h12, 5'h03, 16'h0});
        run(OP_ADD_IMM, 7'h00, 4'h0, 8'hff, 3'b000, {8'h11, 5'h0f, 16'h0});
        run(OP_ADD_IMM_CARRY, 7'h0, 4'h8, 8'h34, 3'b0, {8'h46, 5'h3, 16'h0});
        run(OP_ADD_REG, 7'h05, 4'h8, 8'h0, 3'b0, {8'h46, 5'h3, 16'h857b});
        run(OP_ADD_IMM, 7'h00, 4'h0, 8'hc0, 3'b000, {8'h06, 5'h07, 16'h0});
        run(OP_ADD_REG_CARRY, 7'h5, 4'h0, 8'h0, 3'b0, {8'h82, 5'hb, 16'h0});
        run(OP_AND_REG, 7'h14, 4'h8, 8'h0, 3'b0, {8'h82, 5'h1b, 16'h9400});
        run(OP_ADD_IMM, 7'h00, 4'h0, 8'h7e, 3'b000, {8'h00, 5'h1f, 16'h0});
        run(OP_BIT_CLEAR, 7'h7f, 4'h7, 8'h0, 3'b0, {8'h0, 5'h1f, 16'hff2f});
        run(OP_BIT_CLEAR, 7'h1f, 4'h8, 8'h0, 3'b0, {8'h0, 5'h1f, 16'h9f4e});
        run(OP_SPECIAL, 7'h00, 4'h0, 8'h00, 3'b010, {8'h00, 5'h1d, 16'h0});
        run(OP_NONE, 7'h00, 4'h0, 8'h00, 3'b001, {8'h00, 5'h1c, 16'h0});
        run(OP_SPECIAL, 7'h00, 4'h0, 8'h00, 3'b100, {8'h00, 5'h1f, 16'h0});
        run(OP_SPECIAL, 7'h00, 4'h0, 8'h00, 3'b011, {8'h00, 5'h1c, 16'h0});
        run(OP_SPECIAL, 7'h00, 4'h0, 8'h00, 3'b110, {8'h00, 5'h1f, 16'h0});
        instr = '0;
        watchdog_expired = 1'b0;
        repeat (2) @(posedge clk_sys);
        end_of_test();
    end
endmodule
